// ==== logic/hub_port_requests.sv ====
// Hub port change flags and hub-class control request handling
// Overview of operation
// R1 - Set connect change when the port finishes training into the enabled state.
// R2 - Clear connect change on a matching clear-port-feature request.
// R3 - Set over-current change on either edge, or forced power-off by another port.
// R4 - Clear over-current change on request, or while unpowered with power off.
// R5 - Set reset-done change on every resetting-to-enabled move.
// R6 - Set warm-reset-done change only when that reset was warm.
// R7 - Clear reset, warm, link, config flags on request; hold cleared while power off.
// R8 - Set link-state change on requested U3 resume or any move to inactive.
// R9 - Remote-wake resume never sets the link-state change flag.
// R10 - Link config failure sets config change and disables the port.
// R11 - Buffer descriptor bytes; commit only after the whole transfer succeeds.
// R12 - Descriptor write with nonzero index or wrong length is a request error.
// R13 - Without descriptor write support, answer with a data-stage stall.
// R14 - Only hub descriptor index zero exists.
// R15 - Set hub feature: unknown selector or nonzero index or length is error.
// R16 - Store tier depth; route field least bit sits at depth times four.
// R17 - Tier depth above four, or nonzero index or length, is error.
// R18 - Port requests use type 23h and a valid nonzero port in low index byte.
// R19 - Host keeps upper index byte zero except timeout, link target, wake mask.
// R20 - Accept port reset, warm reset, power, both timeouts, link target, wake mask.
// R21 - Shallow timeout: 00 zero, 01-7F microseconds, 80-FE reserved, FF infinite.
// R22 - Deep timeout: 00 zero, steps of 256 us up to FE, FF infinite.
// R23 - After a deep timeout request, send an LMP with the value to the partner.
// R24 - Host never enables the deep timeout toward an attached hub.
// R25 - Host sends link targets only to an active port in a legal link state.
// R26 - Link target zero moves the link to U0 from any U-state.
module hub_port_requests
  import hub_req_pkg::*;
#(
  parameter bit SUPPORT_SET_DESC = 1'b1
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire apb_req_t                    apb,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  input  wire port_evt_t                   evt,
  input  wire logic [NUM_PORTS-1:0]        oc_pin,
  output port_cmd_t                        port_cmd,
  output logic [NUM_PORTS-1:0]             port_disable_req,
  output logic [2:0]                       tier_depth,
  output logic [4:0]                       route_lsb,
  output logic [1:0]                       hub_feature,
  output logic [NUM_PORTS-1:0][7:0]        shallow_idle_timeout,
  output logic [NUM_PORTS-1:0][7:0]        deep_idle_timeout,
  output logic [NUM_PORTS-1:0][6:0]        shallow_idle_us,
  output logic [NUM_PORTS-1:0]             shallow_idle_infinite,
  output logic [NUM_PORTS-1:0][15:0]       deep_idle_us,
  output logic [NUM_PORTS-1:0]             deep_idle_infinite,
  output logic [NUM_PORTS-1:0][7:0]        wake_mask
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t                                  phase;
    result_t                                 result;
    logic [31:0]                             setup0;
    logic [31:0]                             setup1;
    logic [15:0]                             count;
    logic [DESC_BYTES-1:0][7:0]              staging;
    logic [DESC_BYTES-1:0][7:0]              desc;
    logic [NUM_PORTS-1:0][NUM_FLAGS-1:0]     flags;
    logic [NUM_PORTS-1:0]                    oc_meta;
    logic [NUM_PORTS-1:0]                    oc_sync;
    logic [NUM_PORTS-1:0]                    oc_prev;
    logic [2:0]                              tier;
    logic [1:0]                              hub_feat;
    logic [NUM_PORTS-1:0][7:0]               shallow;
    logic [NUM_PORTS-1:0][7:0]               deep;
    logic [NUM_PORTS-1:0][7:0]               wake;
    port_cmd_t                               cmd;
    logic [NUM_PORTS-1:0]                    disable_req;
  } state_t;

  state_t                              s;
  state_t                              next_s;
  logic [NUM_PORTS-1:0][NUM_FLAGS-1:0] clr;
  logic [NUM_FLAGS-1:0]                set_v;
  logic                                wr;
  logic [7:0]                          rtype;
  logic [7:0]                          rcode;
  logic [15:0]                         rvalue;
  logic [15:0]                         rindex;
  logic [15:0]                         rlength;
  logic [7:0]                          hi;
  logic [7:0]                          pnum;
  logic [PIDX_W-1:0]                   pidx;
  logic                                pvalid;

  // ----------------------------------------------------------------
  // Request field views
  // ----------------------------------------------------------------
  assign rtype   = s.setup0[7:0];
  assign rcode   = s.setup0[15:8];
  assign rvalue  = s.setup0[31:16];
  assign rindex  = s.setup1[15:0];
  assign rlength = s.setup1[31:16];
  assign hi      = rindex[15:8];
  assign pnum    = rindex[7:0];
  assign pidx    = PIDX_W'(pnum - 8'h01);
  assign pvalid  = (pnum != 8'h00) && (pnum <= 8'(NUM_PORTS)); // R18
  assign wr      = apb.psel && apb.penable && apb.pwrite;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    clr = '0;
    set_v = '0;
    next_s.cmd.valid = 1'b0;
    next_s.disable_req = '0;
    // Two flops before anything looks at the over-current pins
    next_s.oc_meta = oc_pin;
    next_s.oc_sync = s.oc_meta;
    next_s.oc_prev = s.oc_sync;

    if (wr) begin
      unique case (apb.paddr)
        ADDR_SETUP0: next_s.setup0 = apb.pwdata;
        ADDR_SETUP1: next_s.setup1 = apb.pwdata;
        ADDR_DATA: begin
          if (s.phase == PH_DATA) begin
            // Extra bytes are dropped but counted, so the length check catches them
            if (s.count < 16'(DESC_BYTES)) begin
              next_s.staging[s.count[3:0]] = apb.pwdata[7:0]; // R11
            end
            next_s.count = s.count + 16'h0001;
          end
        end
        ADDR_CMD: begin
          if (apb.pwdata[CMD_DONE_BIT] && s.phase == PH_DATA) begin
            next_s.phase = PH_IDLE;
            if (rindex == 16'h0000 && rlength == s.count && s.count <= 16'(DESC_BYTES) &&
                rvalue == {DESC_TYPE_HUB, 8'h00}) begin // R12 R14
              next_s.desc = s.staging; // R11
              next_s.result = RES_OK;
            end else begin
              next_s.result = RES_REQ_ERROR; // R12
            end
          end else if (apb.pwdata[CMD_START_BIT] && s.phase == PH_IDLE) begin
            next_s.result = RES_REQ_ERROR;
            if (rtype == RT_HUB_OUT) begin
              if (rcode == REQ_SET_DESCRIPTOR) begin
                if (!SUPPORT_SET_DESC) begin
                  next_s.result = RES_STALL; // R13
                end else begin
                  next_s.phase = PH_DATA;
                  next_s.count = '0;
                  next_s.result = RES_NONE;
                end
              end else if (rcode == REQ_SET_FEATURE) begin
                if (rvalue < HUB_FEAT_COUNT && rindex == 16'h0000 && rlength == 16'h0000) begin // R15
                  next_s.hub_feat[rvalue[0]] = 1'b1;
                  next_s.result = RES_OK;
                end
              end else if (rcode == REQ_SET_HUB_DEPTH) begin
                if (rvalue <= MAX_HUB_DEPTH && rindex == 16'h0000 && rlength == 16'h0000) begin // R17
                  next_s.tier = rvalue[2:0]; // R16
                  next_s.result = RES_OK;
                end
              end
            end else if (rtype == RT_PORT_OUT && pvalid && rlength == 16'h0000) begin // R18
              next_s.cmd.port = pnum;
              next_s.cmd.value = hi;
              if (rcode == REQ_CLEAR_FEATURE && hi == 8'h00) begin
                next_s.result = RES_OK;
                unique case (rvalue)
                  SEL_C_CONNECT: clr[pidx][FLAG_CONNECT] = 1'b1; // R2
                  SEL_C_OVERCUR: clr[pidx][FLAG_OVERCUR] = 1'b1; // R4
                  SEL_C_RESET:   clr[pidx][FLAG_RESET] = 1'b1; // R7
                  SEL_C_WARM:    clr[pidx][FLAG_WARM] = 1'b1; // R7
                  SEL_C_LINK:    clr[pidx][FLAG_LINK] = 1'b1; // R7
                  SEL_C_CONFIG:  clr[pidx][FLAG_CONFIG] = 1'b1; // R7
                  default:       next_s.result = RES_REQ_ERROR;
                endcase
              end else if (rcode == REQ_SET_FEATURE) begin // R20
                unique case (rvalue)
                  SEL_PORT_RESET, SEL_WARM_RESET, SEL_PORT_POWER: begin
                    // Upper index byte must stay zero for these
                    if (hi == 8'h00) begin // R19
                      next_s.result = RES_OK;
                      next_s.cmd.valid = 1'b1;
                      next_s.cmd.kind = (rvalue == SEL_PORT_RESET) ? CMD_PORT_RESET :
                                        (rvalue == SEL_WARM_RESET) ? CMD_WARM_RESET : CMD_PORT_POWER;
                    end
                  end
                  SEL_SHALLOW_IDLE: begin
                    // Reserved codes are refused rather than stored
                    if (hi <= SHALLOW_MAX_US || hi == TIMEOUT_INFINITE) begin // R21
                      next_s.shallow[pidx] = hi;
                      next_s.result = RES_OK;
                    end
                  end
                  SEL_DEEP_IDLE: begin
                    next_s.deep[pidx] = hi; // R22
                    next_s.result = RES_OK;
                    next_s.cmd.valid = 1'b1; // R23
                    next_s.cmd.kind = CMD_DEEP_IDLE_LMP; // R23
                  end
                  SEL_LINK_STATE: begin
                    if (hi <= LINK_TARGET_MAX) begin
                      // Target U0 is forwarded from any U-state; the port logic moves the link
                      next_s.result = RES_OK;
                      next_s.cmd.valid = 1'b1; // R26
                      next_s.cmd.kind = CMD_LINK_STATE; // R26
                    end
                  end
                  SEL_WAKE_MASK: begin
                    next_s.wake[pidx] = hi;
                    next_s.result = RES_OK;
                  end
                  default: next_s.result = RES_REQ_ERROR;
                endcase
              end
            end
          end
        end
        default: ;
      endcase
    end

    // Change flags: a set in the same cycle as a request clear wins
    for (int i = 0; i < NUM_PORTS; i++) begin
      set_v = '0;
      set_v[FLAG_CONNECT] = evt.trained[i]; // R1
      set_v[FLAG_OVERCUR] = (s.oc_sync[i] != s.oc_prev[i]) || evt.oc_forced_off[i]; // R3
      set_v[FLAG_RESET] = evt.reset_done[i]; // R5
      set_v[FLAG_WARM] = evt.reset_done[i] && evt.reset_was_warm[i]; // R6
      // Remote-wake resumes arrive on no input here, so they cannot set this flag
      set_v[FLAG_LINK] = evt.resume_by_request[i] || evt.to_inactive[i]; // R8 R9
      set_v[FLAG_CONFIG] = evt.config_fail[i]; // R10
      next_s.flags[i] = (s.flags[i] & ~clr[i]) | set_v;
      if (evt.power_off[i]) begin
        next_s.flags[i][FLAG_RESET] = 1'b0; // R7
        next_s.flags[i][FLAG_WARM] = 1'b0; // R7
        next_s.flags[i][FLAG_LINK] = 1'b0; // R7
        next_s.flags[i][FLAG_CONFIG] = 1'b0; // R7
        if (evt.in_unpowered[i]) begin
          next_s.flags[i][FLAG_OVERCUR] = 1'b0; // R4
        end
      end
      next_s.disable_req[i] = evt.config_fail[i]; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // APB read side; always ready, unmapped addresses flag an error
  // ----------------------------------------------------------------
  assign pready = 1'b1;

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (apb.paddr)
      ADDR_SETUP0: prdata = s.setup0;
      ADDR_SETUP1: prdata = s.setup1;
      ADDR_DATA:   prdata = {16'h0000, s.count};
      ADDR_CMD:    prdata = {29'h0, s.result, (s.phase == PH_DATA)};
      ADDR_CHANGE: prdata = 32'(s.flags);
      ADDR_HUB:    prdata = {22'h0, s.hub_feat, route_lsb, s.tier};
      ADDR_DESC0:  prdata = s.desc[3:0];
      ADDR_DESC1:  prdata = s.desc[7:4];
      ADDR_DESC2:  prdata = s.desc[11:8];
      default:     pslverr = apb.psel && apb.penable;
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign port_cmd         = s.cmd;
  assign port_disable_req = s.disable_req;
  assign tier_depth       = s.tier;
  assign route_lsb        = {s.tier, 2'b00}; // R16
  assign hub_feature      = s.hub_feat;
  assign shallow_idle_timeout = s.shallow;
  assign deep_idle_timeout    = s.deep;
  assign wake_mask            = s.wake;

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      shallow_idle_infinite[i] = (s.shallow[i] == TIMEOUT_INFINITE); // R21
      shallow_idle_us[i] = shallow_idle_infinite[i] ? 7'h00 : s.shallow[i][6:0]; // R21
      deep_idle_infinite[i] = (s.deep[i] == TIMEOUT_INFINITE); // R22
      deep_idle_us[i] = deep_idle_infinite[i] ? 16'h0000 : {s.deep[i], 8'h00}; // R22
    end
  end

endmodule

// ==== logic/hub_req_pkg.sv ====
// Package for the hub port change and feature request block
package hub_req_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS  = 4;
  localparam int PIDX_W     = 2;
  localparam int NUM_FLAGS  = 6;
  localparam int DESC_BYTES = 12;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SETUP0 = 8'h00;
  localparam logic [7:0] ADDR_SETUP1 = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;
  localparam logic [7:0] ADDR_CHANGE = 8'h10;
  localparam logic [7:0] ADDR_HUB    = 8'h14;
  localparam logic [7:0] ADDR_DESC0  = 8'h18;
  localparam logic [7:0] ADDR_DESC1  = 8'h1c;
  localparam logic [7:0] ADDR_DESC2  = 8'h20;

  // Command register bits
  localparam int CMD_START_BIT = 0;
  localparam int CMD_DONE_BIT  = 1;

  // ----------------------------------------------------------------
  // Change flag positions within one port
  // ----------------------------------------------------------------
  localparam int FLAG_CONNECT = 0;
  localparam int FLAG_OVERCUR = 1;
  localparam int FLAG_RESET   = 2;
  localparam int FLAG_WARM    = 3;
  localparam int FLAG_LINK    = 4;
  localparam int FLAG_CONFIG  = 5;

  // ----------------------------------------------------------------
  // Request encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  RT_HUB_OUT         = 8'h20;
  localparam logic [7:0]  RT_PORT_OUT        = 8'h23;
  localparam logic [7:0]  REQ_CLEAR_FEATURE  = 8'h01;
  localparam logic [7:0]  REQ_SET_FEATURE    = 8'h03;
  localparam logic [7:0]  REQ_SET_DESCRIPTOR = 8'h07;
  localparam logic [7:0]  REQ_SET_HUB_DEPTH  = 8'h0c;
  localparam logic [7:0]  DESC_TYPE_HUB      = 8'h2a;
  localparam logic [15:0] HUB_FEAT_COUNT     = 16'h0002;
  localparam logic [15:0] MAX_HUB_DEPTH      = 16'h0004;

  // Port feature selectors
  localparam logic [15:0] SEL_PORT_RESET     = 16'h0004;
  localparam logic [15:0] SEL_LINK_STATE     = 16'h0005;
  localparam logic [15:0] SEL_PORT_POWER     = 16'h0008;
  localparam logic [15:0] SEL_C_CONNECT      = 16'h0010;
  localparam logic [15:0] SEL_C_OVERCUR      = 16'h0013;
  localparam logic [15:0] SEL_C_RESET        = 16'h0014;
  localparam logic [15:0] SEL_SHALLOW_IDLE   = 16'h0017;
  localparam logic [15:0] SEL_DEEP_IDLE      = 16'h0018;
  localparam logic [15:0] SEL_C_LINK         = 16'h0019;
  localparam logic [15:0] SEL_C_CONFIG       = 16'h001a;
  localparam logic [15:0] SEL_WAKE_MASK      = 16'h001b;
  localparam logic [15:0] SEL_WARM_RESET     = 16'h001c;
  localparam logic [15:0] SEL_C_WARM         = 16'h001d;

  // Timeout and link target encodings
  localparam logic [7:0] TIMEOUT_INFINITE  = 8'hff;
  localparam logic [7:0] SHALLOW_MAX_US    = 8'h7f;
  localparam logic [7:0] LINK_TARGET_U0    = 8'h00;
  localparam logic [7:0] LINK_TARGET_MAX   = 8'h05;
  localparam int         DEEP_STEP_SHIFT   = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RES_NONE, RES_OK, RES_REQ_ERROR, RES_STALL} result_t;
  typedef enum logic {PH_IDLE, PH_DATA} phase_t;
  typedef enum logic [2:0] {
    CMD_PORT_RESET, CMD_WARM_RESET, CMD_PORT_POWER, CMD_LINK_STATE, CMD_DEEP_IDLE_LMP
  } port_cmd_kind_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic           valid;
    logic [7:0]     port;
    port_cmd_kind_t kind;
    logic [7:0]     value;
  } port_cmd_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0] trained;
    logic [NUM_PORTS-1:0] oc_forced_off;
    logic [NUM_PORTS-1:0] reset_done;
    logic [NUM_PORTS-1:0] reset_was_warm;
    logic [NUM_PORTS-1:0] resume_by_request;
    logic [NUM_PORTS-1:0] to_inactive;
    logic [NUM_PORTS-1:0] config_fail;
    logic [NUM_PORTS-1:0] power_off;
    logic [NUM_PORTS-1:0] in_unpowered;
  } port_evt_t;

endpackage

// ==== sim/hub_host_model.sv ====
// Host controller model driving register transfers into the hub block
module hub_host_model
  import hub_req_pkg::*;
(
  output apb_req_t         apb,
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------
  // Callers put the port in the low index byte, upper byte zero unless a value selector; t_port also sends port 0, port 5 and a nonzero upper byte
  // Deep timeouts never go toward a hub, link targets only to active ports
  initial apb = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    rdat = prdata;
    err = pslverr;
    apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask
endmodule

// ==== sim/hub_port_requests_sva.sv ====
// Checker bound to the hub port request block
module hub_port_requests_sva
  import hub_req_pkg::*;
(
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire apb_req_t                  apb,
  input wire port_evt_t                 evt,
  input wire port_cmd_t                 port_cmd,
  input wire logic [NUM_PORTS-1:0]      port_disable_req,
  input wire logic [2:0]                tier_depth,
  input wire logic [4:0]                route_lsb,
  input wire logic [NUM_PORTS-1:0][7:0] deep_idle_timeout
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cmd_wr;
  assign cmd_wr = apb.psel && apb.penable && apb.pwrite && apb.paddr == ADDR_CMD;
  property p_disable; |evt.config_fail |=> port_disable_req == $past(evt.config_fail); endproperty
  a_disable: assert property (p_disable) else $error("disable pulse missing");
  property p_disable_cause; |port_disable_req |-> port_disable_req == $past(evt.config_fail); endproperty
  a_disable_cause: assert property (p_disable_cause) else $error("disable pulse without cause");
  property p_route; route_lsb == {tier_depth, 2'b00}; endproperty
  a_route: assert property (p_route) else $error("route offset not depth times four");
  property p_tier_hold; !cmd_wr |=> $stable(tier_depth); endproperty
  a_tier_hold: assert property (p_tier_hold) else $error("depth moved without a command");
  property p_tier_max; tier_depth <= 3'd4; endproperty
  a_tier_max: assert property (p_tier_max) else $error("depth above four stored");
  property p_lmp; port_cmd.valid && port_cmd.kind == CMD_DEEP_IDLE_LMP |->
    port_cmd.value == deep_idle_timeout[port_cmd.port[1:0] - 2'd1]; endproperty
  a_lmp: assert property (p_lmp) else $error("link packet value differs");
  property p_port; port_cmd.valid |-> port_cmd.port != 8'd0 && port_cmd.port <= 8'(NUM_PORTS); endproperty
  a_port: assert property (p_port) else $error("command to invalid port");
  property p_plain; port_cmd.valid && port_cmd.kind inside {CMD_PORT_RESET, CMD_WARM_RESET, CMD_PORT_POWER}
    |-> port_cmd.value == 8'h00; endproperty
  a_plain: assert property (p_plain) else $error("plain command with upper byte");
  c_disable: cover property (|port_disable_req);
  c_lmp: cover property (port_cmd.valid && port_cmd.kind == CMD_DEEP_IDLE_LMP);
  c_tier: cover property (cmd_wr ##1 tier_depth == 3'd4);
endmodule
bind hub_port_requests hub_port_requests_sva i_sva (.pclk, .presetn, .apb, .evt, .port_cmd,
  .port_disable_req, .tier_depth, .route_lsb, .deep_idle_timeout);

// ==== sim/test_hub_port_requests.sv ====
// Testbench for the hub port change and request block
module test_hub_port_requests
  import hub_req_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // Bench
  // ----------------------------------------------------------
  logic                       pclk = 1'b0;
  logic                       presetn = 1'b0;
  apb_req_t                   apb;
  logic                       pready;
  logic [31:0]                prdata;
  logic                       pslverr;
  port_evt_t                  evt = '0;
  logic [NUM_PORTS-1:0]       oc_pin = '0;
  port_cmd_t                  port_cmd;
  port_cmd_t                  last_cmd = '0;
  logic [2:0]                 tier_depth;
  logic [4:0]                 route_lsb;
  logic [1:0]                 hub_feature;
  logic [NUM_PORTS-1:0][6:0]  shallow_idle_us;
  logic [NUM_PORTS-1:0][15:0] deep_idle_us;
  logic [NUM_PORTS-1:0][7:0]  wake_mask;
  logic [31:0]                q;
  logic                       e;
  int                         err_count = 0;
  int                         num_checks = 0;
  int                         cycles = 0;
  hub_port_requests i_dut (.pclk, .presetn, .apb, .pready, .prdata, .pslverr, .evt, .oc_pin,
    .port_cmd, .port_disable_req(), .tier_depth, .route_lsb, .hub_feature, .shallow_idle_timeout(),
    .deep_idle_timeout(), .shallow_idle_us, .shallow_idle_infinite(), .deep_idle_us,
    .deep_idle_infinite(), .wake_mask);
  hub_host_model i_host (.apb, .pclk, .pready, .prdata, .pslverr);
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (port_cmd.valid === 1'b1) last_cmd <= port_cmd;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    num_checks++;
    if (y !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic req(input logic [31:0] s0, input logic [31:0] s1, input result_t r);
    last_cmd = '0;
    wr(ADDR_SETUP0, s0);
    wr(ADDR_SETUP1, s1);
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_CMD);
    chk("result", 32'(r), 32'(q[2:1]));
  endtask
  task automatic t_depth;
    req(32'h0003_0c20, 32'h0, RES_OK);
    chk("route", 32'd12, 32'(route_lsb));
    req(32'h0005_0c20, 32'h0, RES_REQ_ERROR);
    req(32'h0004_0c20, 32'h1, RES_REQ_ERROR);
    req(32'h0004_0c20, 32'h0001_0000, RES_REQ_ERROR);
    chk("tier", 32'd3, 32'(tier_depth));
    req(32'h0004_0c20, 32'h0, RES_OK);
    rd(ADDR_HUB);
    chk("hub word", 32'h84, q);
  endtask
  task automatic t_feat;
    req(32'h0001_0320, 32'h0, RES_OK);
    chk("feature", 32'h2, 32'(hub_feature));
    req(32'h0002_0320, 32'h0, RES_REQ_ERROR);
    req(32'h0000_0320, 32'h1, RES_REQ_ERROR);
    req(32'h0000_0320, 32'h0001_0000, RES_REQ_ERROR);
  endtask
  task automatic t_port;
    port_cmd_kind_t k[4] = '{CMD_PORT_RESET, CMD_WARM_RESET, CMD_PORT_POWER, CMD_LINK_STATE};
    logic [15:0]    s[4] = '{SEL_PORT_RESET, SEL_WARM_RESET, SEL_PORT_POWER, SEL_LINK_STATE};
    req(32'h0018_0323, 32'h0000_0502, RES_OK);
    chk("lmp", {12'h0, 1'b1, 8'd2, CMD_DEEP_IDLE_LMP, 8'h05}, 32'(last_cmd));
    chk("deep us", 32'd1280, 32'(deep_idle_us[1]));
    req(32'h0018_0323, 32'h0000_fe04, RES_OK);
    chk("deep max", 32'd65024, 32'(deep_idle_us[3]));
    req(32'h0018_0323, 32'h0000_ff04, RES_OK);
    chk("inf", 32'h0, 32'(deep_idle_us[3]));
    req(32'h0017_0323, 32'h0000_7f03, RES_OK);
    req(32'h0017_0323, 32'h0000_8003, RES_REQ_ERROR);
    chk("shallow us", 32'd127, 32'(shallow_idle_us[2]));
    req(32'h0004_0323, 32'h0000_0000, RES_REQ_ERROR);
    req(32'h0004_0323, 32'h0000_0005, RES_REQ_ERROR);
    req(32'h0004_0323, 32'h0000_0101, RES_REQ_ERROR);
    for (int i = 0; i < 4; i++) begin
      req({s[i], 16'h0323}, 32'h4, RES_OK);
      chk("cmd", {12'h0, 1'b1, 8'd4, k[i], 8'h00}, 32'(last_cmd));
    end
    req({SEL_WAKE_MASK, 16'h0323}, 32'h0000_0304, RES_OK);
    chk("wake", 32'h3, 32'(wake_mask[3]));
  endtask
  task automatic t_flags;
    evt <= '{trained: 4'h1, reset_done: 4'h3, reset_was_warm: 4'h2, resume_by_request: 4'h1,
             config_fail: 4'h4, oc_forced_off: 4'h4, to_inactive: 4'h8, default: '0};
    oc_pin <= 4'h1;
    @(posedge pclk);
    evt <= '0;
    repeat (6) @(posedge pclk);
    rd(ADDR_CHANGE);
    chk("change set", 32'h0042_2317, q);
    req(32'h0010_0123, 32'h1, RES_OK);
    req(32'h001a_0123, 32'h3, RES_OK);
    rd(ADDR_CHANGE);
    chk("change clr", 32'h0040_2316, q);
    // Pin fall, reset done while power off
    evt <= '{power_off: 4'h3, in_unpowered: 4'h1, default: '0};
    oc_pin <= 4'h0;
    @(posedge pclk);
    evt.reset_done <= 4'h2;
    @(posedge pclk);
    evt.reset_done <= 4'h0;
    repeat (6) @(posedge pclk);
    rd(ADDR_CHANGE);
    chk("change off", 32'h0040_2000, q);
    evt <= '0;
  endtask
  task automatic desc(input logic [31:0] s0, input logic [31:0] s1, input int n, input result_t r,
                      input logic [31:0] old, input logic [31:0] now);
    wr(ADDR_SETUP0, s0);
    wr(ADDR_SETUP1, s1);
    wr(ADDR_CMD, 32'h1);
    for (int i = 0; i < n; i++) begin
      wr(ADDR_DATA, 32'h10 + 32'(i));
    end
    rd(ADDR_DESC0);
    chk("desc held", old, q);
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_CMD);
    chk("desc result", 32'(r), 32'(q[2:1]));
    rd(ADDR_DESC0);
    chk("desc word", now, q);
  endtask
  task automatic t_desc;
    desc(32'h2a00_0720, 32'h000c_0000, 12, RES_OK, 32'h0, 32'h1312_1110);
    rd(ADDR_DESC2);
    chk("desc top", 32'h1b1a_1918, q);
    desc(32'h2a00_0720, 32'h0004_0000, 3, RES_REQ_ERROR, 32'h1312_1110, 32'h1312_1110);
    desc(32'h2a00_0720, 32'h0004_0001, 4, RES_REQ_ERROR, 32'h1312_1110, 32'h1312_1110);
    desc(32'h2a01_0720, 32'h0004_0000, 4, RES_REQ_ERROR, 32'h1312_1110, 32'h1312_1110);
    rd(8'h40);
    chk("unmapped", 32'h1, {31'h0, e});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_depth();
    t_feat();
    t_port();
    t_flags();
    t_desc();
    end_sim();
  end
endmodule
